// *** rtl/tpw_pkg.sv ***
package tpw_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_TWO = 4'h1;
    localparam logic [3:0] ADDR_CMP1_HIGH = 4'h2;
    localparam logic [3:0] ADDR_CMP1_LOW = 4'h3;
    localparam logic [3:0] ADDR_CMP2_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CMP2_LOW = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h8;
    localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h9;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'hA;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'hB;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_LEVEL1 = 0;
    localparam int BIT_LEVEL2 = 1;
    localparam int BIT_CAP_IRQ_EN = 2;
    localparam int BIT_PIN_EN = 0;
    localparam int BIT_PWM = 1;
    localparam int BIT_SINGLE = 2;
    localparam int BIT_CLK_LO = 3;
    localparam int BIT_CLK_HI = 4;
    localparam int BIT_CAP1 = 0;
    localparam int BIT_CAP2 = 1;
    localparam int BIT_CMP1 = 2;
    localparam int BIT_CMP2 = 3;

    // ****************************************
    // Reset values and clock selection codes
    // ****************************************
    localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] CMP_RESET = 16'hFFFF;
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tpw_bus_t;

endpackage

// *** rtl/tpw_timer.sv ***
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - Period comes from the period compare, pulse edge from the first compare.
// - In pulse mode both compare units serve the waveform, none independent.
// - In pulse mode written compare values load into active copies only at period end.
// - First match drives level one to the pin, period match level two.
// - Pin enable hands the pin to the compare output, else port data.
// - Levels one/zero give high time equal to period minus first value.
// - Equal levels give a constant pin level.
// - Clock select picks core clock divided by 2, 4 or 8.
// - Clock select may pick the external clock input instead.
// - In pulse mode each period match reloads the counter with FFFC.
// - High byte write suspends that compare until the low byte arrives.
// - Compare flags are never set in pulse mode.
// - In pulse mode the period match sets capture flag one; interrupt if enabled and unmasked.
// - In pulse mode capture pin one is ignored; capture pin two still captures.
// - Pulse mode wins when single pulse mode is also selected.
module tpw_timer
    import tpw_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port.
    input wire tpw_bus_t bus,
    output logic [7:0] rdata,
    // Timer pins, all synchronous to core_clk.
    input wire logic ext_clk,
    input wire logic first_capture_pin,
    input wire logic second_capture_pin,
    input wire logic port_data,
    input wire logic global_irq_mask,
    output logic compare_output_pin,
    output logic single_pulse_active,
    output logic irq
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] control_one_reg;
    logic [7:0] control_two_reg;
    logic [15:0] first_compare_value;
    logic [15:0] period_compare_value;
    logic [15:0] cmp1_active_reg;
    logic [15:0] cmp2_active_reg;
    logic cmp1_pending_reg;
    logic cmp2_pending_reg;
    logic cmp1_held_reg;
    logic cmp2_held_reg;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic [15:0] count_reg;
    logic [15:0] second_capture_value;
    logic [2:0] div_reg;
    logic ext_prev_reg;
    logic cap1_prev_reg;
    logic cap2_prev_reg;
    logic pin_level_reg;
    logic tick;
    logic pwm_mode;
    logic match1;
    logic match2;
    logic cap1_evt;
    logic cap2_evt;
    logic [3:0] status_set;
    logic [1:0] clk_sel;

    assign clk_sel = control_two_reg[BIT_CLK_HI:BIT_CLK_LO];
    assign pwm_mode = control_two_reg[BIT_PWM];
    // Pulse mode overrides single pulse when both are set.
    assign single_pulse_active = control_two_reg[BIT_SINGLE] & ~pwm_mode;

    // Prescaler: a free divider whose taps give one-cycle enables.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_reg <= 3'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            ext_prev_reg <= ext_clk;
        end
    end

    always_comb begin
        case (clk_sel)
            CLK_DIV2: tick = div_reg[0];
            CLK_DIV4: tick = (div_reg[1:0] == 2'h3);
            CLK_DIV8: tick = (div_reg == 3'h7);
            default: tick = ext_clk & ~ext_prev_reg;
        endcase
    end

    // Matches are qualified by the tick so each fires once per count value.
    assign match1 = tick & ~cmp1_held_reg & (count_reg == cmp1_active_reg);
    assign match2 = tick & ~cmp2_held_reg & (count_reg == cmp2_active_reg);

    // Counter; in pulse mode the period match restarts it from the reload value.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_reg <= COUNT_RELOAD;
        end else if (pwm_mode && match2) begin
            count_reg <= COUNT_RELOAD;
        end else if (tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Software copies; a high byte write holds the compare until the low byte.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_compare_value <= CMP_RESET;
            period_compare_value <= CMP_RESET;
            cmp1_held_reg <= 1'b0;
            cmp2_held_reg <= 1'b0;
            control_one_reg <= 8'h00;
            control_two_reg <= 8'h00;
            mask_reg <= 4'h0;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_CMP1_HIGH) begin
                first_compare_value[15:8] <= bus.wdata;
                cmp1_held_reg <= 1'b1;
            end else if (bus.addr == ADDR_CMP1_LOW) begin
                first_compare_value[7:0] <= bus.wdata;
                cmp1_held_reg <= 1'b0;
            end else if (bus.addr == ADDR_CMP2_HIGH) begin
                period_compare_value[15:8] <= bus.wdata;
                cmp2_held_reg <= 1'b1;
            end else if (bus.addr == ADDR_CMP2_LOW) begin
                period_compare_value[7:0] <= bus.wdata;
                cmp2_held_reg <= 1'b0;
            end else if (bus.addr == ADDR_CONTROL_ONE) begin
                control_one_reg <= bus.wdata;
            end else if (bus.addr == ADDR_CONTROL_TWO) begin
                control_two_reg <= bus.wdata;
            end else if (bus.addr == ADDR_IRQ_MASK) begin
                mask_reg <= bus.wdata[3:0];
            end
        end
    end

    // Double buffer: outside pulse mode values apply at once, inside only at
    // the period match, so the pin never sees a half-updated edge.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmp1_active_reg <= CMP_RESET;
            cmp2_active_reg <= CMP_RESET;
            cmp1_pending_reg <= 1'b0;
            cmp2_pending_reg <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == ADDR_CMP1_LOW) begin
                cmp1_pending_reg <= 1'b1;
            end else if (!pwm_mode || match2) begin
                cmp1_pending_reg <= 1'b0;
            end
            if (bus.wr && bus.addr == ADDR_CMP2_LOW) begin
                cmp2_pending_reg <= 1'b1;
            end else if (!pwm_mode || match2) begin
                cmp2_pending_reg <= 1'b0;
            end
            if (cmp1_pending_reg && (!pwm_mode || match2)) begin
                cmp1_active_reg <= first_compare_value;
            end
            if (cmp2_pending_reg && (!pwm_mode || match2)) begin
                cmp2_active_reg <= period_compare_value;
            end
        end
    end

    // Output level: period match has priority when both match together.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_level_reg <= 1'b0;
        end else if (match2) begin
            pin_level_reg <= control_one_reg[BIT_LEVEL2];
        end else if (match1) begin
            pin_level_reg <= control_one_reg[BIT_LEVEL1];
        end
    end

    // Pin enable gives the pin to the compare output, else port data.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_output_pin <= 1'b0;
        end else begin
            compare_output_pin <= control_two_reg[BIT_PIN_EN] ? pin_level_reg : port_data;
        end
    end

    // Capture inputs: rising edges. Pin one is cut off in pulse mode.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cap1_prev_reg <= 1'b0;
            cap2_prev_reg <= 1'b0;
            second_capture_value <= 16'h0000;
        end else begin
            cap1_prev_reg <= first_capture_pin;
            cap2_prev_reg <= second_capture_pin;
            if (cap2_evt) begin
                second_capture_value <= count_reg;
            end
        end
    end
    assign cap1_evt = first_capture_pin & ~cap1_prev_reg & ~pwm_mode;
    assign cap2_evt = second_capture_pin & ~cap2_prev_reg;

    // Event sources. In pulse mode the period match feeds capture flag one and
    // the compare flags stay silent, unused by the waveform.
    always_comb begin
        status_set = 4'h0;
        status_set[BIT_CAP1] = cap1_evt | (pwm_mode & match2);
        status_set[BIT_CAP2] = cap2_evt;
        status_set[BIT_CMP1] = match1 & ~pwm_mode;
        status_set[BIT_CMP2] = match2 & ~pwm_mode;
    end

    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_reg <= 4'h0;
        end else if (bus.wr && bus.addr == ADDR_STATUS) begin
            status_reg <= (status_reg & ~bus.wdata[3:0]) | status_set;
        end else begin
            status_reg <= status_reg | status_set;
        end
    end

    // Capture flags need the capture enable and a clear global mask.
    always_comb begin
        irq = 1'b0;
        if (|(status_reg[1:0] & mask_reg[1:0]) && control_one_reg[BIT_CAP_IRQ_EN] && !global_irq_mask) begin
            irq = 1'b1;
        end
        if (|(status_reg[3:2] & mask_reg[3:2])) begin
            irq = 1'b1;
        end
    end

    // Read port: data stands the cycle after the strobe.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            if (bus.addr == ADDR_CONTROL_ONE) begin
                rdata <= control_one_reg;
            end else if (bus.addr == ADDR_CONTROL_TWO) begin
                rdata <= control_two_reg;
            end else if (bus.addr == ADDR_CMP1_HIGH) begin
                rdata <= first_compare_value[15:8];
            end else if (bus.addr == ADDR_CMP1_LOW) begin
                rdata <= first_compare_value[7:0];
            end else if (bus.addr == ADDR_CMP2_HIGH) begin
                rdata <= period_compare_value[15:8];
            end else if (bus.addr == ADDR_CMP2_LOW) begin
                rdata <= period_compare_value[7:0];
            end else if (bus.addr == ADDR_STATUS) begin
                rdata <= {4'h0, status_reg};
            end else if (bus.addr == ADDR_IRQ_MASK) begin
                rdata <= {4'h0, mask_reg};
            end else if (bus.addr == ADDR_CAPTURE_HIGH) begin
                rdata <= second_capture_value[15:8];
            end else if (bus.addr == ADDR_CAPTURE_LOW) begin
                rdata <= second_capture_value[7:0];
            end else if (bus.addr == ADDR_COUNT_HIGH) begin
                rdata <= count_reg[15:8];
            end else if (bus.addr == ADDR_COUNT_LOW) begin
                rdata <= count_reg[7:0];
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_period_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_mode && match2 |=> count_reg == COUNT_RELOAD) else $error("Counter not reloaded.");
    a_level_two: assert property (@(posedge core_clk) disable iff (!rst_n)
        match2 |=> pin_level_reg == $past(control_one_reg[1])) else $error("Period level wrong.");
    a_level_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        match1 && !match2 |=> pin_level_reg == $past(control_one_reg[0])) else $error("First level wrong.");
    a_no_cmp_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_mode && $past(pwm_mode) |-> !$rose(status_reg[2]) && !$rose(status_reg[3]))
        else $error("Compare flag set in pulse mode.");
    a_cap_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_mode && match2 |=> status_reg[0]) else $error("Capture flag missing.");
    a_held_no_match: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmp1_held_reg && tick && count_reg == cmp1_active_reg && !match2 |=> $stable(pin_level_reg))
        else $error("Match while held.");
    a_buffer_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_mode && $past(pwm_mode) && $changed(cmp2_active_reg) |-> $past(match2))
        else $error("Compare applied mid-period.");
    a_cap1_cut: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_mode && !match2 |=> !$rose(status_reg[0])) else $error("Capture one active in pulse mode.");
    a_pin_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        control_two_reg[0] ##1 control_two_reg[0] |-> compare_output_pin == $past(pin_level_reg))
        else $error("Pin not dedicated.");
    a_steady_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        (match1 || match2) && control_one_reg[0] == control_one_reg[1] && pin_level_reg == control_one_reg[0]
        |=> $stable(pin_level_reg)) else $error("Equal levels toggled.");
    a_single_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm_mode |-> !single_pulse_active) else $error("Single pulse with pwm.");

    c_period_end: cover property (@(posedge core_clk) disable iff (!rst_n) pwm_mode && match2);
    c_pulse_edge: cover property (@(posedge core_clk) disable iff (!rst_n) pwm_mode && match1);
    c_capture_two: cover property (@(posedge core_clk) disable iff (!rst_n) pwm_mode && cap2_evt);
    c_irq_raise: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));

endmodule

// *** testbench/tpw_testbench.sv ***
`timescale 1ns/1ns
module testbench
    import tpw_pkg::*;
;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    tpw_bus_t bus = '0;
    logic [7:0] rdata;
    logic ext_clk = 1'b0;
    logic first_capture_pin = 1'b0;
    logic second_capture_pin = 1'b0;
    logic port_data = 1'b0;
    logic global_irq_mask = 1'b0;
    logic compare_output_pin;
    logic single_pulse_active;
    logic irq;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    int bad;
    int c1;
    int c2;
    logic [7:0] rd_val;
    int presc [4] = '{2, 4, 8, 6};
    logic [1:0] sel [4] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_EXT};

    tpw_timer i_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(bus),
        .rdata(rdata),
        .ext_clk(ext_clk),
        .first_capture_pin(first_capture_pin),
        .second_capture_pin(second_capture_pin),
        .port_data(port_data),
        .global_irq_mask(global_irq_mask),
        .compare_output_pin(compare_output_pin),
        .single_pulse_active(single_pulse_active),
        .irq(irq)
    );

    // Core clock at 20 MHz.
    always #25 core_clk = ~core_clk;

    // External timer clock: one rising edge every six core cycles, so one tick per six cycles.
    always begin
        repeat (3) @(posedge core_clk);
        ext_clk <= ~ext_clk;
    end

    // ****************************************
    // Bench tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The expected high time in core cycles: ticks between the two matches times the tick spacing.
    function automatic logic [15:0] exp_high(input int lo, input int hi, input int p);
        return 16'((hi - lo) * p);
    endfunction

    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // High byte first: the low byte releases the compare.
    task automatic wr16(input logic [3:0] hi_addr, input logic [3:0] lo_addr, input logic [15:0] v);
        reg_wr(hi_addr, v[15:8]);
        reg_wr(lo_addr, v[7:0]);
    endtask

    task automatic wait_pin(input logic lvl, output int cnt);
        cnt = 0;
        while (compare_output_pin !== lvl && cnt < 5000) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        if (cnt >= 5000) begin
            chk(16'h0000, 16'h0001, "output pin never reached the awaited level");
        end
    endtask

    // Software order: period, pulse, levels, then enables and clock.
    task automatic setup(input int lo, input int hi, input logic [1:0] lv, input logic [7:0] ctl);
        do_reset();
        wr16(ADDR_CMP2_HIGH, ADDR_CMP2_LOW, 16'(hi));
        wr16(ADDR_CMP1_HIGH, ADDR_CMP1_LOW, 16'(lo));
        reg_wr(ADDR_CONTROL_ONE, {5'h00, 1'b1, lv});
        reg_wr(ADDR_CONTROL_TWO, ctl);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h0E9B0C8E));
        do_reset();
        reg_rd(ADDR_COUNT_HIGH, rd_val);
        chk(16'(rd_val), 16'h00FF, "counter does not start near its reload value");
        reg_rd(4'hF, rd_val);
        chk(16'(rd_val), 16'h0000, "unmapped read not zero");
        chk(16'(irq), 16'h0000, "interrupt high after reset");
        // Every clock source, single pulse also selected; odd passes mask the interrupt globally.
        for (int k = 0; k < 4; k++) begin
            c1 = 10 + int'($urandom % 6);
            c2 = c1 + 2 + int'($urandom % 8);
            @(posedge core_clk);
            global_irq_mask <= k[0];
            setup(c1, c2, 2'b01, {3'h0, sel[k], 3'b111});
            chk(16'(single_pulse_active), 16'h0000, "single pulse active in pulse mode");
            wait_pin(1'b0, n);
            wait_pin(1'b1, n);
            wait_pin(1'b0, n);
            chk(16'(n), exp_high(c1, c2, presc[k]), "high time wrong");
            reg_rd(ADDR_STATUS, rd_val);
            chk(16'(rd_val[3:2]), 16'h0000, "compare flag set in pulse mode");
            chk(16'(rd_val[0]), 16'h0001, "period match flag missing");
            reg_wr(ADDR_IRQ_MASK, 8'h03);
            #1;
            chk(16'(irq), 16'(!k[0]), "interrupt level wrong");
        end
        // A new period written mid-pulse must leave the running pulse alone.
        wait_pin(1'b1, n);
        fork
            wait_pin(1'b0, n);
            wr16(ADDR_CMP2_HIGH, ADDR_CMP2_LOW, 16'(c2 + 4));
        join
        chk(16'(n), exp_high(c1, c2, 6), "new period applied mid-pulse");
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        chk(16'(n), exp_high(c1, c2 + 4, 6), "new period not applied");
        // Capture pin two still captures; pin one pulses alongside and is ignored.
        @(posedge core_clk);
        second_capture_pin <= 1'b1;
        first_capture_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        second_capture_pin <= 1'b0;
        first_capture_pin <= 1'b0;
        reg_rd(ADDR_STATUS, rd_val);
        chk(16'(rd_val[1]), 16'h0001, "capture on pin two missing");
        // Leave pulse mode, clear both capture flags by writing ones.
        @(posedge core_clk);
        global_irq_mask <= 1'b0;
        reg_wr(ADDR_CONTROL_TWO, 8'h00);
        reg_wr(ADDR_STATUS, 8'h03);
        reg_rd(ADDR_STATUS, rd_val);
        chk(16'(rd_val[1:0]), 16'h0000, "capture flags not cleared");
        chk(16'(irq), 16'h0000, "interrupt stays after clear");
        // Equal levels: the pin settles and never moves.
        for (int lv = 0; lv < 4; lv += 3) begin
            setup(10, 14, 2'(lv), {3'h0, CLK_DIV2, 3'b011});
            repeat (60) @(posedge core_clk);
            bad = 0;
            repeat (64) begin
                @(posedge core_clk);
                #1;
                if (compare_output_pin !== lv[0]) begin
                    bad++;
                end
            end
            chk(16'(bad), 16'h0000, "pin moved with equal levels");
        end
        // Pin enable clear: the port level reaches the pin.
        reg_wr(ADDR_CONTROL_TWO, 8'h04);
        #1;
        chk(16'(single_pulse_active), 16'h0001, "single pulse select not seen");
        repeat (8) begin
            @(posedge core_clk);
            port_data <= 1'($urandom);
            repeat (3) @(posedge core_clk);
            #1;
            chk(16'(compare_output_pin), 16'(port_data), "port level not on pin");
        end
        close_out();
    end

    // Watchdog: the sequence needs well under 20,000 cycles.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        close_out();
    end
endmodule
